//--- rtl/pin_mux_defs.vh
// Constants for the port A pins two to six function multiplexer
`ifndef PIN_MUX_DEFS_VH
`define PIN_MUX_DEFS_VH

// Four-bit pin configuration field codes
`define CFG_ANALOG 4'h0
`define CFG_GPIO_OUT 4'h1
`define CFG_GPIO_OD 4'h5
`define CFG_ALT_OUT 4'h9
`define CFG_ALT_OD 4'hd

// Field positions in the low and high port A config words
`define LOW_PIN_TWO_HI 11
`define LOW_PIN_TWO_LO 8
`define LOW_PIN_THREE_HI 15
`define LOW_PIN_THREE_LO 12
`define HIGH_PIN_FOUR_HI 3
`define HIGH_PIN_FOUR_LO 0
`define HIGH_PIN_FIVE_HI 7
`define HIGH_PIN_FIVE_LO 4
`define HIGH_PIN_SIX_HI 11
`define HIGH_PIN_SIX_LO 8

// Timer 2 remap bits and serial SPI master bit
`define REMAP_CH4_BIT 7
`define REMAP_CH2_BIT 5
`define SPI_MASTER_BIT 4

// Serial controller 2 mode codes
`define MODE_SPI 2'h2
`define MODE_I2C 2'h3

// Reset levels of the synchronisers and of the synchronised pin inputs
`define SYNC_IDLE 6'h3f
`define GPIO_IN_IDLE 5'h1f

// Bit positions in the synchroniser vector
`define SYNC_PIN_TWO 0
`define SYNC_PIN_THREE 1
`define SYNC_PIN_FIVE 3
`define SYNC_PIN_SIX 4
`define SYNC_EXT_RESET 5

`endif

//--- rtl/port_a_pins_two_to_six_mux.v
// Pin function multiplexer for port A pins two to six
`timescale 1ns/1ns
`include "pin_mux_defs.vh"

module port_a_pins_two_to_six_mux (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // Pin configuration and peripheral settings
  input wire [15:0] port_a_low_config,
  input wire [15:0] port_a_high_config,
  input wire [7:0] timer2_remap_option,
  input wire timer2_ch4_output_enable,
  input wire timer2_ch2_output_enable,
  input wire timer1_output_enable,
  input wire [1:0] serial2_mode_select,
  input wire [7:0] serial2_spi_config,
  input wire trace_enable,
  input wire trace_four_wire,
  // General-purpose data, index 0 is pin two
  input wire [4:0] gpio_out,
  output reg [4:0] gpio_in,
  // Peripheral outputs toward the pins
  input wire timer2_channel_four_out,
  input wire timer2_channel_two_out,
  input wire timer1_channel_three_out,
  input wire serial2_i2c_clock_out,
  input wire serial2_spi_clock_out,
  input wire cpu_trace_clock,
  input wire cpu_trace_data_two,
  input wire cpu_trace_data_three,
  input wire packet_trace_frame,
  input wire packet_trace_data,
  // Peripheral inputs taken from the pins
  output reg timer2_channel_four_in,
  output reg timer2_channel_two_in,
  output reg timer1_channel_three_in,
  output reg serial2_i2c_clock_in,
  output reg serial2_spi_clock_in,
  output reg serial2_slave_select_n,
  // Analog switch enables
  output reg analog_input_four,
  output reg analog_input_five,
  // Bootloader request capture
  input wire external_reset_n,
  output reg bootloader_request,
  // Pins
  input wire port_a_pin_two_in,
  output reg port_a_pin_two_out,
  output reg port_a_pin_two_oe,
  input wire port_a_pin_three_in,
  output reg port_a_pin_three_out,
  output reg port_a_pin_three_oe,
  input wire port_a_pin_four_in,
  output reg port_a_pin_four_out,
  output reg port_a_pin_four_oe,
  input wire port_a_pin_five_in,
  output reg port_a_pin_five_out,
  output reg port_a_pin_five_oe,
  input wire port_a_pin_six_in,
  output reg port_a_pin_six_out,
  output reg port_a_pin_six_oe
);

  // Reset release and pin synchronisers
  reg [1:0] reset_sync;
  wire rst_n;
  reg [5:0] meta;
  reg [5:0] sync;
  wire [4:0] sync_pins;
  wire sync_two;
  wire sync_three;
  wire sync_five;
  wire sync_six;
  wire sync_ext_reset_n;

  // Next pin drive, index 0 is pin two
  reg [4:0] next_out;
  reg [4:0] next_oe;

  // Decoded configuration fields and peripheral settings
  wire [3:0] field_two;
  wire [3:0] field_three;
  wire [3:0] field_four;
  wire [3:0] field_five;
  wire [3:0] field_six;
  wire spi_mode;
  wire spi_master;
  wire spi_slave;
  wire i2c_mode;
  wire ch4_home;
  wire ch2_home;
  wire ch4_owns;
  wire ch2_owns;

  // Default drive for a pin whose field holds a general-purpose code
  function [1:0] gpio_drive;
    input [3:0] field;
    input value;
    begin
      if (field == `CFG_GPIO_OUT)
        gpio_drive = {1'b1, value};
      else if (field == `CFG_GPIO_OD)
        gpio_drive = {~value, 1'b0};
      else
        gpio_drive = 2'h0;
    end
  endfunction

  // Drive of a pin shared by the two trace units: packet trace while core
  // trace is off, core trace data only on the 4-wire interface, else released
  function [1:0] trace_drive;
    input core_on;
    input four_wire;
    input packet;
    input data;
    begin
      if (!core_on)
        trace_drive = {1'b1, packet};
      else if (four_wire)
        trace_drive = {1'b1, data};
      else
        trace_drive = 2'h0;
    end
  endfunction

  // Reset release through two flip-flops
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      reset_sync <= 2'h0;
    else
      reset_sync <= {reset_sync[0], 1'b1};
  end
  assign rst_n = reset_sync[1];

  // Two-stage synchronisers for the pins and the external reset pin
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= `SYNC_IDLE;
      sync <= `SYNC_IDLE;
    end
    else
    begin
      meta <= {external_reset_n, port_a_pin_six_in, port_a_pin_five_in,
               port_a_pin_four_in, port_a_pin_three_in, port_a_pin_two_in};
      sync <= meta;
    end
  end

  // Synchronised pin levels by name
  assign sync_pins = sync[`SYNC_PIN_SIX:`SYNC_PIN_TWO];
  assign sync_two = sync[`SYNC_PIN_TWO];
  assign sync_three = sync[`SYNC_PIN_THREE];
  assign sync_five = sync[`SYNC_PIN_FIVE];
  assign sync_six = sync[`SYNC_PIN_SIX];
  assign sync_ext_reset_n = sync[`SYNC_EXT_RESET];

  // Configuration fields of each pin
  assign field_two = port_a_low_config[`LOW_PIN_TWO_HI:`LOW_PIN_TWO_LO];
  assign field_three = port_a_low_config[`LOW_PIN_THREE_HI:`LOW_PIN_THREE_LO];
  assign field_four = port_a_high_config[`HIGH_PIN_FOUR_HI:`HIGH_PIN_FOUR_LO];
  assign field_five = port_a_high_config[`HIGH_PIN_FIVE_HI:`HIGH_PIN_FIVE_LO];
  assign field_six = port_a_high_config[`HIGH_PIN_SIX_HI:`HIGH_PIN_SIX_LO];
  // Serial controller 2 mode decode
  assign spi_mode = (serial2_mode_select == `MODE_SPI);
  assign spi_master = serial2_spi_config[`SPI_MASTER_BIT];
  assign spi_slave = spi_mode && !spi_master;
  assign i2c_mode = (serial2_mode_select == `MODE_I2C);
  // Timer channel inputs stay on their home pins while unremapped
  assign ch4_home = !timer2_remap_option[`REMAP_CH4_BIT];
  assign ch2_home = !timer2_remap_option[`REMAP_CH2_BIT];
  // Timer owns the pin only while unremapped and its output is enabled
  assign ch4_owns = ch4_home && timer2_ch4_output_enable;
  assign ch2_owns = ch2_home && timer2_ch2_output_enable;

  // Output selection per pin
  always @*
  begin
    {next_oe[0], next_out[0]} = gpio_drive(field_two, gpio_out[0]);
    {next_oe[1], next_out[1]} = gpio_drive(field_three, gpio_out[1]);
    {next_oe[2], next_out[2]} = gpio_drive(field_four, gpio_out[2]);
    {next_oe[3], next_out[3]} = gpio_drive(field_five, gpio_out[3]);
    {next_oe[4], next_out[4]} = gpio_drive(field_six, gpio_out[4]);
    // Pin two
    if (field_two == `CFG_ALT_OUT)
    begin
      if (ch4_owns)
        {next_oe[0], next_out[0]} = {1'b1, timer2_channel_four_out};
      else if (spi_mode && spi_master)
        {next_oe[0], next_out[0]} = {1'b1, serial2_spi_clock_out};
      else
        {next_oe[0], next_out[0]} = 2'h0;
    end
    else if (field_two == `CFG_ALT_OD)
    begin
      if (!ch4_owns && i2c_mode)
        {next_oe[0], next_out[0]} = {~serial2_i2c_clock_out, 1'b0};
      else
        {next_oe[0], next_out[0]} = 2'h0;
    end
    // Pin three
    if (field_three == `CFG_ALT_OUT)
    begin
      if (ch2_owns)
        {next_oe[1], next_out[1]} = {1'b1, timer2_channel_two_out};
      else if (trace_enable)
        {next_oe[1], next_out[1]} = {1'b1, cpu_trace_clock};
      else
        {next_oe[1], next_out[1]} = 2'h0;
    end
    // Pin four
    if (field_four == `CFG_ALT_OUT)
      {next_oe[2], next_out[2]} = trace_drive(trace_enable, trace_four_wire,
        packet_trace_frame, cpu_trace_data_two);
    // Pin five
    if (field_five == `CFG_ALT_OUT)
      {next_oe[3], next_out[3]} = trace_drive(trace_enable, trace_four_wire,
        packet_trace_data, cpu_trace_data_three);
    // Pin six
    if (field_six == `CFG_ALT_OUT)
    begin
      if (timer1_output_enable)
        {next_oe[4], next_out[4]} = {1'b1, timer1_channel_three_out};
      else
        {next_oe[4], next_out[4]} = 2'h0;
    end
  end

  // Registered pin drive
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {port_a_pin_two_oe, port_a_pin_two_out} <= 2'h0;
      {port_a_pin_three_oe, port_a_pin_three_out} <= 2'h0;
      {port_a_pin_four_oe, port_a_pin_four_out} <= 2'h0;
      {port_a_pin_five_oe, port_a_pin_five_out} <= 2'h0;
      {port_a_pin_six_oe, port_a_pin_six_out} <= 2'h0;
    end
    else
    begin
      {port_a_pin_two_oe, port_a_pin_two_out} <= {next_oe[0], next_out[0]};
      {port_a_pin_three_oe, port_a_pin_three_out} <= {next_oe[1], next_out[1]};
      {port_a_pin_four_oe, port_a_pin_four_out} <= {next_oe[2], next_out[2]};
      {port_a_pin_five_oe, port_a_pin_five_out} <= {next_oe[3], next_out[3]};
      {port_a_pin_six_oe, port_a_pin_six_out} <= {next_oe[4], next_out[4]};
    end
  end

  // Analog switch enables follow the pin fields
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      analog_input_four <= 1'b0;
      analog_input_five <= 1'b0;
    end
    else
    begin
      analog_input_four <= (field_four == `CFG_ANALOG);
      analog_input_five <= (field_five == `CFG_ANALOG);
    end
  end

  // Peripheral inputs; a deselected input rests at its idle level
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gpio_in <= `GPIO_IN_IDLE;
      timer2_channel_four_in <= 1'b0;
      timer2_channel_two_in <= 1'b0;
      timer1_channel_three_in <= 1'b0;
      serial2_i2c_clock_in <= 1'b1;
      serial2_spi_clock_in <= 1'b0;
      serial2_slave_select_n <= 1'b1;
    end
    else
    begin
      gpio_in <= sync_pins;
      timer2_channel_four_in <= ch4_home && sync_two;
      timer2_channel_two_in <= ch2_home && sync_three;
      timer1_channel_three_in <= sync_six;
      serial2_i2c_clock_in <= i2c_mode ? sync_two : 1'b1;
      serial2_spi_clock_in <= spi_slave && sync_two;
      serial2_slave_select_n <= spi_slave ? sync_three : 1'b1;
    end
  end

  // Bootloader request follows inverted pin five while external reset is low, then holds;
  // both levels pass the same synchroniser depth, so release cannot outrun the pin
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      bootloader_request <= 1'b0;
    else if (!sync_ext_reset_n)
      bootloader_request <= !sync_five;
  end

endmodule // port_a_pins_two_to_six_mux

//--- tb/pin_mux_partner.sv
// Model of the timers, serial controller and trace units that feed the pins
`timescale 1ns/1ns
module pin_mux_partner (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Peripheral levels toward the pins
  output logic [9:0] per
);
  // Levels move on the falling edge, clear of the sampling edge
  always @(negedge mclk or negedge resetn)
  begin
    if (!resetn)
      per <= 10'h2a5;
    else
      per <= {per[8:0], per[9] ^ per[6]};
  end
endmodule // pin_mux_partner

//--- tb/port_a_pins_two_to_six_mux_chk.sv
// Assertions on the ports of the pin multiplexer
`timescale 1ns/1ns
module pin_mux_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Settings
  input wire logic [15:0] port_a_low_config,
  input wire logic [15:0] port_a_high_config,
  input wire logic [7:0] timer2_remap_option,
  input wire logic timer2_ch4_output_enable,
  input wire logic timer2_ch2_output_enable,
  input wire logic timer1_output_enable,
  input wire logic trace_enable,
  // Peripheral sides
  input wire logic timer2_channel_four_out,
  input wire logic timer2_channel_two_out,
  input wire logic timer1_channel_three_out,
  input wire logic packet_trace_frame,
  input wire logic timer1_channel_three_in,
  input wire logic analog_input_four,
  input wire logic analog_input_five,
  // Pins
  input wire logic port_a_pin_two_out,
  input wire logic port_a_pin_two_oe,
  input wire logic port_a_pin_three_out,
  input wire logic port_a_pin_three_oe,
  input wire logic port_a_pin_four_out,
  input wire logic port_a_pin_four_oe,
  input wire logic port_a_pin_six_in,
  input wire logic port_a_pin_six_out,
  input wire logic port_a_pin_six_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [2:0] up;
  wire ok = (up == 3'h7);
  // Cycles since reset release; the internal reset copy needs a few edges
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      up <= 3'h0;
    else if (!ok)
      up <= up + 3'h1;
  end
  sequence six_rises;
    ok ##0 $rose(port_a_pin_six_in);
  endsequence
  AST_PIN_TWO_TIMER: assert property (ok && $past(port_a_low_config[11:8] == 4'h9 &&
    !timer2_remap_option[7] && timer2_ch4_output_enable) |-> port_a_pin_two_oe &&
    port_a_pin_two_out == $past(timer2_channel_four_out)) else $error("pin two timer");
  AST_PIN_THREE_TIMER: assert property (ok && $past(port_a_low_config[15:12] == 4'h9 &&
    !timer2_remap_option[5] && timer2_ch2_output_enable) |-> port_a_pin_three_oe &&
    port_a_pin_three_out == $past(timer2_channel_two_out)) else $error("pin three timer");
  AST_PIN_SIX_TIMER: assert property (ok && $past(port_a_high_config[11:8] == 4'h9 &&
    timer1_output_enable) |-> port_a_pin_six_oe &&
    port_a_pin_six_out == $past(timer1_channel_three_out)) else $error("pin six timer");
  AST_PIN_FOUR_FRAME: assert property (ok && $past(port_a_high_config[3:0] == 4'h9 &&
    !trace_enable) |-> port_a_pin_four_oe && port_a_pin_four_out == $past(packet_trace_frame))
    else $error("pin four frame");
  AST_ANALOG_FOUR: assert property (ok |->
    analog_input_four == ($past(port_a_high_config[3:0]) == 4'h0)) else $error("analog four");
  AST_ANALOG_FIVE: assert property (ok |->
    analog_input_five == ($past(port_a_high_config[7:4]) == 4'h0)) else $error("analog five");
  AST_TIMER1_INPUT: assert property (six_rises |-> ##3 timer1_channel_three_in)
    else $error("timer 1 input lag");
  AST_ALT_NO_SOURCE: assert property (ok && $past(port_a_high_config[11:8] == 4'h9 &&
    !timer1_output_enable) |-> !port_a_pin_six_oe) else $error("pin six driven");
endmodule // pin_mux_chk
bind port_a_pins_two_to_six_mux pin_mux_chk chk_u (.*);

//--- tb/port_a_pins_two_to_six_mux_tb.sv
// Self-checking bench for the port A pins two to six multiplexer
`timescale 1ns/1ns
module port_a_pins_two_to_six_mux_tb;
  // Stimulus and observed signals
  logic mclk = 1'h0, resetn = 1'h0, external_reset_n = 1'h1;
  logic trace_enable = 1'h0, trace_four_wire = 1'h0;
  logic [15:0] port_a_low_config = 16'h0, port_a_high_config = 16'h0;
  logic [7:0] timer2_remap_option = 8'h0, serial2_spi_config = 8'h0;
  logic timer2_ch4_output_enable = 1'h0, timer2_ch2_output_enable = 1'h0;
  logic timer1_output_enable = 1'h0, bootloader_request, slv;
  logic [1:0] serial2_mode_select = 2'h0;
  logic [4:0] gpio_out = 5'h0, gpio_in, pin = 5'h0, pin_q1, pin_q2, pin_q3;
  wire [4:0] oe, out;
  wire t4_in, t2_in, t1_in, i2c_in, spi_in, ssel_n;
  logic [9:0] per, per_q;
  int errors = 0, tests_run = 0, cycles = 0;
  wire t4 = !timer2_remap_option[7] && timer2_ch4_output_enable;
  wire t2 = !timer2_remap_option[5] && timer2_ch2_output_enable;
  pin_mux_partner partner_u (.mclk(mclk), .resetn(resetn), .per(per));
  port_a_pins_two_to_six_mux dut_u (.*, .timer2_channel_four_in(t4_in),
    .timer2_channel_two_in(t2_in), .timer1_channel_three_in(t1_in),
    .serial2_i2c_clock_in(i2c_in), .serial2_spi_clock_in(spi_in),
    .serial2_slave_select_n(ssel_n), .analog_input_four(), .analog_input_five(),
    .timer2_channel_four_out(per[9]), .timer2_channel_two_out(per[8]),
    .timer1_channel_three_out(per[7]), .serial2_i2c_clock_out(per[6]),
    .serial2_spi_clock_out(per[5]), .cpu_trace_clock(per[4]), .cpu_trace_data_two(per[3]),
    .cpu_trace_data_three(per[2]), .packet_trace_frame(per[1]), .packet_trace_data(per[0]),
    .port_a_pin_two_in(pin[0]), .port_a_pin_two_out(out[0]), .port_a_pin_two_oe(oe[0]),
    .port_a_pin_three_in(pin[1]), .port_a_pin_three_out(out[1]), .port_a_pin_three_oe(oe[1]),
    .port_a_pin_four_in(pin[2]), .port_a_pin_four_out(out[2]), .port_a_pin_four_oe(oe[2]),
    .port_a_pin_five_in(pin[3]), .port_a_pin_five_out(out[3]), .port_a_pin_five_oe(oe[3]),
    .port_a_pin_six_in(pin[4]), .port_a_pin_six_out(out[4]), .port_a_pin_six_oe(oe[4]));
  // Clock, peripheral capture and hang guard
  initial
    forever #50 mclk = ~mclk;
  always @(posedge mclk)
  begin
    per_q <= per;
    pin_q1 <= pin;
    pin_q2 <= pin_q1;
    pin_q3 <= pin_q2;
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      end_of_test();
    end
  end
  // Expected {checked, enable, level} of one pin from its field code
  function automatic logic [2:0] exp_pin(input logic [3:0] f, input logic g, ok, v, od, odv);
    case (f)
      4'h1: exp_pin = {2'h3, g};
      4'h5: exp_pin = {1'h1, ~g, 1'h0};
      4'h9: exp_pin = {1'h1, ok, v};
      4'hd: exp_pin = {1'h1, od && odv, 1'h0};
      default: exp_pin = 3'h4;
    endcase
  endfunction
  // Field codes 0, 1, 5, 9, d and 3, one nibble each
  function automatic logic [3:0] rf();
    rf = 4'(24'h3d9510 >> (4 * $urandom_range(5)));
  endfunction
  task automatic check_pin(input int i, input logic [2:0] e);
    tests_run++;
    if (e[2] && (oe[i] !== e[1] || (e[1] && out[i] !== e[0])))
    begin
      errors++;
      $display("wrong value at %0t: pin index %0d", $time, i);
    end
  endtask
  task automatic check_val(input logic [4:0] got, input logic [4:0] exp, input int id);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: output %0d", $time, id);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(30566));
    repeat (6) @(negedge mclk);
    resetn = 1'h1;
    repeat (8) @(negedge mclk);
    repeat (400)
    begin
      port_a_low_config = {rf(), rf(), 8'h0};
      port_a_high_config = {4'h0, rf(), rf(), rf()};
      timer2_remap_option = 8'($urandom);
      serial2_spi_config = 8'($urandom);
      {timer2_ch4_output_enable, timer2_ch2_output_enable, timer1_output_enable} = 3'($urandom);
      serial2_mode_select = 2'($urandom);
      {trace_enable, trace_four_wire} = 2'($urandom);
      gpio_out = 5'($urandom);
      pin = 5'($urandom);
      @(negedge mclk);
      check_pin(0, exp_pin(port_a_low_config[11:8], gpio_out[0], t4 || (serial2_mode_select ==
        2'h2 && serial2_spi_config[4]), t4 ? per_q[9] : per_q[5], !t4 &&
        serial2_mode_select == 2'h3, ~per_q[6]));
      check_pin(1, exp_pin(port_a_low_config[15:12], gpio_out[1], t2 || trace_enable,
        t2 ? per_q[8] : per_q[4], 1'h0, 1'h0));
      check_pin(2, exp_pin(port_a_high_config[3:0], gpio_out[2], !trace_enable || trace_four_wire,
        trace_enable ? per_q[3] : per_q[1], 1'h0, 1'h0));
      check_pin(3, exp_pin(port_a_high_config[7:4], gpio_out[3], !trace_enable || trace_four_wire,
        trace_enable ? per_q[2] : per_q[0], 1'h0, 1'h0));
      check_pin(4, exp_pin(port_a_high_config[11:8], gpio_out[4], timer1_output_enable,
        per_q[7], 1'h0, 1'h0));
      // Peripheral inputs show the pin level taken three edges earlier
      slv = serial2_mode_select == 2'h2 && !serial2_spi_config[4];
      check_val(t4_in, !timer2_remap_option[7] && pin_q3[0], 1);
      check_val(t2_in, !timer2_remap_option[5] && pin_q3[1], 2);
      check_val(t1_in, pin_q3[4], 3);
      check_val(i2c_in, serial2_mode_select == 2'h3 ? pin_q3[0] : 1'h1, 4);
      check_val(spi_in, slv && pin_q3[0], 5);
      check_val(ssel_n, slv ? pin_q3[1] : 1'h1, 6);
      check_val(gpio_in, pin_q3, 7);
    end
    $display("test random pin routing done");
    // Pin five held low across an external reset sets the request, kept after it ends
    check_val(bootloader_request, 1'h0, 8);
    pin[3] = 1'h0;
    external_reset_n = 1'h0;
    repeat (8) @(negedge mclk);
    external_reset_n = 1'h1;
    pin[3] = 1'h1;
    repeat (8) @(negedge mclk);
    check_val(bootloader_request, 1'h1, 8);
    external_reset_n = 1'h0;
    repeat (8) @(negedge mclk);
    check_val(bootloader_request, 1'h0, 8);
    $display("test bootloader request done");
    end_of_test();
  end
endmodule // port_a_pins_two_to_six_mux_tb
